//--- rtl/pin_out_mux.sv
// Purpose: Routes one peripheral output function to each remappable pin
// Assumes: Selectors are stable flops from the register file
// Notes: Outputs are registered, so a pin follows its function one cycle later
`timescale 1ns/1ps
module pin_out_mux (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  pin_sel_if.mux bus
);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      bus.pin_data <= '0;
      bus.pin_oe <= '0;
      bus.pin_remap <= '0;
    end
    else
    begin
      for (int p = 0; p < pin_out_pkg::NUM_PINS; p++)
      begin
        // Function zero leaves the pin to its general-purpose port
        if (bus.sel[p] == pin_out_pkg::SEL_NONE)
        begin
          bus.pin_data[p] <= 1'b0;
          bus.pin_oe[p] <= 1'b0;
          bus.pin_remap[p] <= 1'b0;
        end
        else
        begin
          bus.pin_data[p] <= bus.func_data[bus.sel[p]];
          bus.pin_oe[p] <= bus.func_oe[bus.sel[p]];
          bus.pin_remap[p] <= 1'b1;
        end
      end
    end
  end

  chk_zero_idle_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus.sel[0] == pin_out_pkg::SEL_NONE) |=> (!bus.pin_remap[0] && !bus.pin_oe[0]))
    else $error("pin 8 driven with selector zero");

  chk_pin_follows_func: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus.sel[3] != pin_out_pkg::SEL_NONE) ##1 !$past(rst_i)
      |-> bus.pin_data[3] == $past(bus.func_data[bus.sel[3]]))
    else $error("pin 11 does not follow its selected function");

  cov_pin_routed: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    bus.pin_remap[0] && bus.pin_oe[0]);

endmodule : pin_out_mux

//--- rtl/pin_out_pkg.sv
// Purpose: Constants and helpers for the remappable pin output select block
// Assumes: APB word access, one 16-bit mapping register per aligned word
// Notes: Offsets are byte addresses within the block's window
package pin_out_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W = 6;
  localparam int NUM_PINS = 14;
  localparam int FIRST_PIN = 8;
  localparam int NUM_FUNC = 64;
  localparam int NUM_REGS = 7;
  localparam int REG_IDX_W = 3;

  localparam logic [ADDR_W-1:0] OFS_SEL_8_9 = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SEL_10_11 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SEL_12_13 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SEL_14_15 = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_SEL_16_17 = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_SEL_18_19 = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_SEL_20_21 = 12'h018;

  // Field positions inside each mapping register
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;

  // Selector index of the pin that reduced-pin variants lack
  localparam int PIN15_IDX = 15 - FIRST_PIN;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = (addr[1:0] == 2'h0) && (addr <= OFS_SEL_20_21);
  endfunction : reg_hit

  function automatic logic [REG_IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[REG_IDX_W+1:2];
  endfunction : reg_index

endpackage : pin_out_pkg

//--- rtl/pin_out_select.sv
// Purpose: APB register file and pin routing for remappable output pins 8 to 21
// Assumes: APB4 master, zero wait state, word-aligned accesses
// Notes: Each register packs the even pin selector low and the odd pin one high
`timescale 1ns/1ps
module pin_out_select #(
  parameter bit PIN15_PRESENT = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pin_out_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [pin_out_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [pin_out_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [pin_out_pkg::NUM_FUNC-1:0] func_data_i,
  input wire logic [pin_out_pkg::NUM_FUNC-1:0] func_oe_i,
  output logic [pin_out_pkg::NUM_PINS-1:0] pin_data_o,
  output logic [pin_out_pkg::NUM_PINS-1:0] pin_oe_o,
  output logic [pin_out_pkg::NUM_PINS-1:0] pin_remap_o
);

  pin_sel_if sel_bus ();

  logic [pin_out_pkg::SEL_W-1:0] sel_q [pin_out_pkg::NUM_PINS];
  logic [pin_out_pkg::DATA_W-1:0] prdata_q;
  logic setup_phase;
  logic access_phase;
  logic hit;
  logic [pin_out_pkg::REG_IDX_W-1:0] idx;
  logic wr_en;
  logic [pin_out_pkg::REG_IDX_W:0] even_slot;
  logic [pin_out_pkg::REG_IDX_W:0] odd_slot;
  logic odd_blocked;
  logic [pin_out_pkg::NUM_PINS*pin_out_pkg::SEL_W-1:0] sel_flat;

  // Register r holds the selectors of slots 2r and 2r+1
  function automatic logic [pin_out_pkg::REG_IDX_W:0] field_slot(
    input logic [pin_out_pkg::REG_IDX_W-1:0] r,
    input logic odd
  );
    field_slot = {r, odd};
  endfunction : field_slot

  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign hit = pin_out_pkg::reg_hit(paddr_i);
  assign idx = pin_out_pkg::reg_index(paddr_i);
  assign wr_en = access_phase && pwrite_i && hit;
  assign even_slot = field_slot(idx, 1'b0);
  assign odd_slot = field_slot(idx, 1'b1);
  // A reduced-pin part has no pin 15, so its field is left without a write path
  assign odd_blocked = !PIN15_PRESENT && (odd_slot == 4'(pin_out_pkg::PIN15_IDX));

  // No wait states; unmapped addresses answer with an error in the same cycle
  assign pready_o = access_phase;
  assign pslverr_o = access_phase && !hit;
  assign prdata_o = prdata_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      for (int p = 0; p < pin_out_pkg::NUM_PINS; p++)
      begin
        sel_q[p] <= pin_out_pkg::SEL_RESET;
      end
    end
    else if (wr_en)
    begin
      // Only the 6-bit fields are stored; the pad bits have no flops
      if (pstrb_i[0])
      begin
        sel_q[even_slot] <= pwdata_i[pin_out_pkg::EVEN_LSB +: pin_out_pkg::SEL_W];
      end
      if (pstrb_i[1] && !odd_blocked)
      begin
        sel_q[odd_slot] <= pwdata_i[pin_out_pkg::ODD_LSB +: pin_out_pkg::SEL_W];
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop with no wait state
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prdata_q <= '0;
    end
    else if (setup_phase)
    begin
      prdata_q <= '0;
      if (hit && !pwrite_i)
      begin
        prdata_q[pin_out_pkg::EVEN_LSB +: pin_out_pkg::SEL_W] <= sel_q[even_slot];
        prdata_q[pin_out_pkg::ODD_LSB +: pin_out_pkg::SEL_W] <= sel_q[odd_slot];
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < pin_out_pkg::NUM_PINS; p++)
    begin
      sel_bus.sel[p] = sel_q[p];
    end
  end

  // Packed view of every selector, so one check can see any of them move
  always_comb
  begin
    for (int p = 0; p < pin_out_pkg::NUM_PINS; p++)
    begin
      sel_flat[p*pin_out_pkg::SEL_W +: pin_out_pkg::SEL_W] = sel_q[p];
    end
  end

  assign sel_bus.func_data = func_data_i;
  assign sel_bus.func_oe = func_oe_i;
  assign pin_data_o = sel_bus.pin_data;
  assign pin_oe_o = sel_bus.pin_oe;
  assign pin_remap_o = sel_bus.pin_remap;

  pin_out_mux u_mux (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .bus(sel_bus.mux)
  );

  chk_pad_bits_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pready_o |-> (prdata_o[31:14] == '0) && (prdata_o[7:6] == 2'h0))
    else $error("unimplemented read bits not zero");

  chk_reset_clears_sel: assert property (@(posedge clk_sys_i)
    rst_i |=> (sel_q[0] == '0) && (sel_q[13] == '0) && (sel_q[6] == '0))
    else $error("selector not cleared by reset");

  chk_odd_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && pstrb_i[1] && (paddr_i == pin_out_pkg::OFS_SEL_8_9))
      |=> sel_q[1] == $past(pwdata_i[13:8]))
    else $error("odd field write did not reach pin 9 selector");

  chk_even_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && pstrb_i[0] && (paddr_i == pin_out_pkg::OFS_SEL_20_21))
      |=> sel_q[12] == $past(pwdata_i[5:0]))
    else $error("even field write did not reach pin 20 selector");

  chk_read_back_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup_phase && !pwrite_i && (paddr_i == pin_out_pkg::OFS_SEL_16_17))
      |=> (prdata_o[13:8] == $past(sel_q[9])) && (prdata_o[5:0] == $past(sel_q[8])))
    else $error("read back does not match selectors 16 and 17");

  chk_pin15_absent: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !PIN15_PRESENT |-> sel_q[pin_out_pkg::PIN15_IDX] == '0)
    else $error("absent pin 15 selector is not zero");

  chk_unmapped_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup_phase && !hit) ##1 penable_i |-> pslverr_o && (prdata_o == '0))
    else $error("unmapped access not flagged");

  cov_write_cycle: cover property (@(posedge clk_sys_i) disable iff (rst_i) wr_en);

  cov_read_nonzero: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    pready_o && !pwrite_i && (prdata_o != '0));

  cov_unmapped: cover property (@(posedge clk_sys_i) disable iff (rst_i) pslverr_o);

  // Writes outside a mapped register, or with a field strobe low, must leave selectors alone
  chk_idle_keeps_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wr_en |=> $stable(sel_flat))
    else $error("selector changed without a write");

  chk_strobe_off_keeps: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && !pstrb_i[0] && (paddr_i == pin_out_pkg::OFS_SEL_8_9))
      |=> sel_q[0] == $past(sel_q[0]))
    else $error("pin 8 selector written with its strobe low");

  chk_pad_write_dropped: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && (pstrb_i[1:0] == 2'h3) && (paddr_i == pin_out_pkg::OFS_SEL_10_11))
      |=> (sel_q[2] == $past(pwdata_i[5:0])) && (sel_q[3] == $past(pwdata_i[13:8])))
    else $error("pad bits leaked into selectors 10 and 11");

  chk_odd_pin21_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && pstrb_i[1] && (paddr_i == pin_out_pkg::OFS_SEL_20_21))
      |=> sel_q[13] == $past(pwdata_i[13:8]))
    else $error("odd field write did not reach pin 21 selector");

  chk_pin15_writable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (PIN15_PRESENT && wr_en && pstrb_i[1] && (paddr_i == pin_out_pkg::OFS_SEL_14_15))
      |=> sel_q[pin_out_pkg::PIN15_IDX] == $past(pwdata_i[13:8]))
    else $error("present pin 15 selector did not take its write");

  chk_pin14_beside_gap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && pstrb_i[0] && (paddr_i == pin_out_pkg::OFS_SEL_14_15))
      |=> sel_q[6] == $past(pwdata_i[5:0]))
    else $error("pin 14 selector did not take its write");

  // Read data must show the selectors as they stood at the setup edge
  chk_read_back_pair: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup_phase && !pwrite_i && (paddr_i == pin_out_pkg::OFS_SEL_8_9))
      |=> (prdata_o[13:8] == $past(sel_q[1])) && (prdata_o[5:0] == $past(sel_q[0])))
    else $error("read back does not match selectors 8 and 9");

  // A write answers with zero data so stale selectors never show on the bus
  chk_reset_read_zero: assert property (@(posedge clk_sys_i)
    rst_i |=> prdata_o == '0)
    else $error("read data not cleared by reset");

  chk_write_reads_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup_phase && pwrite_i) |=> prdata_o == '0)
    else $error("read data not zero during a write");

  cov_odd_strobe_only: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_en && (pstrb_i[1:0] == 2'h2));

endmodule : pin_out_select

//--- rtl/pin_sel_if.sv
// Purpose: Carries selectors and routed pin values between register file and mux
// Assumes: One clock domain
// Notes: Peripheral signals enter here from the top-level ports
`timescale 1ns/1ps
interface pin_sel_if;
  logic [pin_out_pkg::SEL_W-1:0] sel [pin_out_pkg::NUM_PINS];
  logic [pin_out_pkg::NUM_FUNC-1:0] func_data;
  logic [pin_out_pkg::NUM_FUNC-1:0] func_oe;
  logic [pin_out_pkg::NUM_PINS-1:0] pin_data;
  logic [pin_out_pkg::NUM_PINS-1:0] pin_oe;
  logic [pin_out_pkg::NUM_PINS-1:0] pin_remap;

  modport regs (
    output sel,
    output func_data,
    output func_oe,
    input pin_data,
    input pin_oe,
    input pin_remap
  );

  modport mux (
    input sel,
    input func_data,
    input func_oe,
    output pin_data,
    output pin_oe,
    output pin_remap
  );
endinterface : pin_sel_if

//--- verif/periph_func_model.sv
// Purpose: Peripheral output functions feeding the pin mux
// Assumes: One clock, values change after the rising edge
// Notes: Moves every cycle unless frozen, so a stale selection cannot pass
`timescale 1ns/1ps
module periph_func_model #(
  parameter logic [63:0] HOLD_PAT = 64'h0
) (
  input wire logic clk_sys_i,
  input wire logic hold_i,
  output logic [63:0] func_data_o,
  output logic [63:0] func_oe_o
);
  always_ff @(posedge clk_sys_i)
  begin
    if (hold_i)
    begin
      func_data_o <= HOLD_PAT;
      func_oe_o <= ~HOLD_PAT;
    end
    else
    begin
      func_data_o <= {func_data_o[62:0], ~func_data_o[63]};
      func_oe_o <= ~func_oe_o;
    end
  end
endmodule : periph_func_model

//--- verif/tb_remappable_pin_output_select.sv
// Purpose: Register and routing tests for the pin output select block
// Assumes: Zero wait state slave, pins follow two edges after a write
// Notes: A second, reduced-pin instance shares the bus for read checks
`timescale 1ns/1ps
module tb_remappable_pin_output_select;
  localparam logic [63:0] PAT = 64'h0123456789abcdef;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b1, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, rd_small, rdata_o, rdata_s;
  logic [3:0] pstrb = 4'hf;
  logic [63:0] fdata, foe;
  logic [13:0] pdata, poe, premap, exp_d;
  int errors = 0, compares = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  periph_func_model #(.HOLD_PAT(PAT)) u_func (.clk_sys_i(clk_sys_i), .hold_i(hold),
    .func_data_o(fdata), .func_oe_o(foe));
  pin_out_select dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(rdata_o), .pready_o(pready), .pslverr_o(pslverr),
    .func_data_i(fdata), .func_oe_i(foe), .pin_data_o(pdata), .pin_oe_o(poe),
    .pin_remap_o(premap));
  pin_out_select #(.PIN15_PRESENT(1'b0)) dut_small (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(rdata_s), .pready_o(), .pslverr_o(),
    .func_data_i(fdata), .func_oe_i(foe), .pin_data_o(), .pin_oe_o(), .pin_remap_o());

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = rdata_o;
    rd_small = rdata_s;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic [13:0] d, input logic [13:0] oe, input logic [13:0] rm);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("pin_data", 32'(d), 32'(pdata));
    chk("pin_oe", 32'(oe), 32'(poe));
    chk("pin_remap", 32'(rm), 32'(premap));
  endtask : pins

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    hold <= 1'b0;
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0, 4'hf);
      chk("reset value", 32'h0, rd);
    end
    pins(14'h0, 14'h0, 14'h0);
    $display("test reset done");
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, 12'(4 * k), 32'hffffffff, 4'hf);
      apb(1'b0, 12'(4 * k), 32'h0, 4'hf);
      chk("all ones", 32'h3f3f, rd);
      chk("reduced pin", (k == 3) ? 32'h3f : 32'h3f3f, rd_small);
    end
    apb(1'b1, 12'h000, 32'h0505, 4'h2);
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b1, j ? 12'h002 : 12'h01c, 32'h0, 4'hf);
      chk("unmapped err", 32'h1, 32'(err));
      apb(1'b0, j ? 12'h002 : 12'h01c, 32'h0, 4'hf);
      chk("unmapped data", 32'h0, rd);
    end
    apb(1'b0, 12'h000, 32'h0, 4'hf);
    chk("odd field only", 32'h053f, rd);
    $display("test access done");
    // Frozen functions so each pin's expected value is fixed
    hold <= 1'b1;
    for (int n = 1; n < 64; n++)
    begin
      for (int k = 0; k < 7; k++)
        apb(1'b1, 12'(4 * k), {18'h0, 6'(n), 2'h0, 6'(64 - n)}, 4'hf);
      for (int i = 0; i < 14; i++)
        exp_d[i] = PAT[(i % 2) ? n : 64 - n];
      pins(exp_d, ~exp_d, 14'h3fff);
    end
    for (int k = 0; k < 7; k++)
      apb(1'b1, 12'(4 * k), 32'h0, 4'hf);
    pins(14'h0, 14'h0, 14'h0);
    $display("test routing done");
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    end_of_test();
  end
endmodule : tb_remappable_pin_output_select
